// ### dv/rwr_drive_model.sv
// behavioural read channel answering each retry attempt of the engine
`timescale 1ns/1ns
module rwr_drive_model
    import rwr_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       attemptReq,
    input  rwr_step_t       step,
    input  wire logic [8:0] okAt,
    input  wire logic       corr,
    output logic            attemptDone = 1'b0,
    output logic            attemptOk = 1'b0,
    output logic            attemptCorrectable = 1'b0
);
    // answer one cycle after each request; idle qualifiers toggle so a
    // stale level never passes for a real answer
    always @(posedge clock) begin
        attemptDone <= attemptReq && !rst;
        if (attemptReq) begin
            attemptOk          <= step.attempt == okAt;
            attemptCorrectable <= corr;
        end else begin
            attemptOk          <= !attemptOk;
            attemptCorrectable <= !attemptCorrectable;
        end
    end
endmodule

// ### dv/testbench.sv
// self-checking bench of the recovery policy engine
`timescale 1ns/1ns
module testbench;
    import rwr_pkg::*;
    logic        clock = 1'b0, rst = 1'b1, pageWrite = 1'b0;
    logic [7:0]  pageLen = 8'h00, pageFlags = 8'h00, pageReadRetry = 8'h00;
    logic [7:0]  pageBurst = 8'h00, pageWriteRetry = 8'h00;
    logic        errStart = 1'b0, cmdEnd = 1'b0, corr = 1'b0;
    rwr_err_t    errInfo = '0;
    logic [8:0]  okAt = 9'h000;
    logic        attemptDone, attemptOk, attemptCorrectable, pageReject;
    logic        busy, attemptReq, eccApply, recovered, abortCmd, sendBlock;
    logic        terminateCmd, statusValid;
    rwr_cfg_t    cfg, expCfg;
    rwr_step_t   step;
    rwr_status_t status;
    logic [40:0] p;
    logic [55:0] r;
    logic [7:0]  seen;
    int          n_fail = 0, comparisons = 0, cycles = 0, nAtt, k;
    // page rows: refused flag, length, flags, read, burst, write retries
    localparam logic [40:0] PAGES [8] = '{
        {1'b0, 40'h0A_28_00_0B_03}, {1'b0, 40'h06_04_05_00_77},
        {1'b1, 40'h08_00_01_00_01}, {1'b1, 40'h0A_00_01_05_01},
        {1'b1, 40'h0A_02_01_00_01}, {1'b1, 40'h0A_03_01_0B_01},
        {1'b0, 40'h0A_06_01_0B_01}, {1'b0, 40'h0A_20_00_00_00}};
    // recovery rows: flags rr wr kind okAt attempts events sense
    localparam logic [55:0] CASES [9] = '{
        56'h20_00_00_0_00_02_0D_3, 56'h00_14_00_0_00_16_09_3,
        56'h00_02_00_1_00_04_30_0, 56'h01_02_00_1_00_04_09_3,
        56'h08_02_00_1_00_00_30_0, 56'h04_02_00_0_03_03_10_1,
        56'h06_02_00_0_01_01_13_1, 56'h00_05_01_2_00_03_09_3,
        56'h08_00_00_5_00_02_09_3};

    rwr_recovery i_rwr_recovery (.clock, .rst, .pageWrite, .pageLen,
        .pageFlags, .pageReadRetry, .pageBurst, .pageWriteRetry, .errStart,
        .errInfo, .attemptDone, .attemptOk, .attemptCorrectable, .cmdEnd,
        .cfg, .pageReject, .busy, .attemptReq, .step, .eccApply, .recovered,
        .abortCmd, .sendBlock, .terminateCmd, .statusValid, .status);
    rwr_drive_model i_rwr_drive_model (.clock, .rst, .attemptReq, .step,
        .okAt, .corr, .attemptDone, .attemptOk, .attemptCorrectable);

    always #4 clock = ~clock;

    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic wrap_up();
        if (n_fail == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // table position of an attempt; the table wraps to the re-seek step
    function automatic int posOf(int n);
        return (n <= 20) ? n : 3 + (n - 3) % 18;
    endfunction

    function automatic rwr_action_t expAct(int n);
        if (posOf(n) == 3) return ACT_RESEEK;
        if (posOf(n) <= 4) return ACT_READ;
        return (posOf(n) <= 8) ? ACT_SLICE : ACT_OFFSET;
    endfunction

    // signed so that it widens the same way as the step's amount
    function automatic logic signed [2:0] expAmt(int n);
        int q = posOf(n) - 9;
        if (q < 0) return (q < -2) ? 3'h7 : 3'h1;
        return ((q / 2) % 2) ? -3'(q / 4 + 1) : 3'(q / 4 + 1);
    endfunction

    task automatic page(logic [39:0] v);
        {pageLen, pageFlags, pageReadRetry, pageBurst, pageWriteRetry} = v;
        pageWrite = 1'b1;
        @(negedge clock);
        pageWrite = 1'b0;
    endtask

    // hang guard, far above the longest recovery walk
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            wrap_up();
        end
    end

    // watch every attempt and gather the one-cycle pulses mid-cycle
    always @(negedge clock) begin
        if (attemptReq === 1'b1) begin
            nAtt++;
            chk("attempt", nAtt, step.attempt);
            chk("action", expAct(nAtt), step.action);
            if (step.action inside {ACT_SLICE, ACT_OFFSET})
                chk("amount", expAmt(nAtt), step.amount);
        end
        seen |= {2'b00, eccApply, recovered, abortCmd, sendBlock,
            terminateCmd, statusValid};
    end

    initial begin
        repeat (10) @(negedge clock);
        rst = 1'b0;
        expCfg = {RST_TFB, RST_EER, RST_PER, RST_DTE, RST_DCR,
            RST_READ_RETRY, RST_WRITE_RETRY};
        chk("cfg", expCfg, cfg);
        chk("busy", 1'b0, busy);
        foreach (PAGES[i]) begin
            p = PAGES[i];
            page(p[39:0]);
            if (!p[40])
                expCfg = {p[29], p[27:24], p[23:16],
                    (p[39:32] == 8'h06) ? expCfg.writeRetry : p[7:0]};
            chk("pageReject", p[40], pageReject);
            chk("cfg", expCfg, cfg);
            // let an edge pass so the strobe is never set twice in one step
            @(negedge clock);
        end
        foreach (CASES[i]) begin
            r = CASES[i];
            page({8'h0A, r[55:48], r[47:40], 8'h0B, r[39:32]});
            errInfo = {r[29], r[30], r[28], 32'h0000_0100 + 32'(i)};
            okAt = {1'b0, r[27:20]};
            corr = r[28];
            nAtt = 0;
            seen = 8'h00;
            errStart = 1'b1;
            @(negedge clock);
            errStart = 1'b0;
            // a second error while busy must not restart the walk
            if (i == 1) begin
                repeat (3) @(negedge clock);
                errStart = 1'b1;
                @(negedge clock);
                errStart = 1'b0;
            end
            for (k = 0; k < 200 && busy !== 1'b0; k++) @(negedge clock);
            @(negedge clock);
            chk("attempts", r[19:12], nAtt);
            chk("events", r[11:4], seen);
            if (!seen[0]) begin
                cmdEnd = 1'b1;
                @(negedge clock);
                cmdEnd = 1'b0;
                @(negedge clock);
                chk("statusValid", 1'b1, seen[0]);
            end
            chk("sense", {r[3:0] != 4'h0, r[3:0]},
                {status.check, status.senseKey});
            if (r[3:0] != 4'h0)
                chk("addr", 32'h0000_0100 + 32'(i), status.addr);
        end
        // reset in mid-walk: engine back to idle, page back to defaults
        nAtt = 0;
        errStart = 1'b1;
        @(negedge clock);
        errStart = 1'b0;
        @(negedge clock);
        rst = 1'b1;
        @(negedge clock);
        rst = 1'b0;
        expCfg = {RST_TFB, RST_EER, RST_PER, RST_DTE, RST_DCR,
            RST_READ_RETRY, RST_WRITE_RETRY};
        repeat (2) begin
            @(negedge clock);
            chk("busy", 1'b0, busy);
            chk("cfg", expCfg, cfg);
            chk("step", 9'h000, step.attempt);
        end
        wrap_up();
    end
endmodule

// ### hdl/rwr_page_regs.sv
// holder of the recovery page written by mode select
`timescale 1ns/1ns
module rwr_page_regs
    import rwr_pkg::*;
(
    input  wire logic     clock,
    input  wire logic     rst,
    input  wire logic     pageWrite,
    input  wire logic [7:0] pageLen,
    input  wire logic [7:0] pageFlags,
    input  wire logic [7:0] pageReadRetry,
    input  wire logic [7:0] pageBurst,
    input  wire logic [7:0] pageWriteRetry,
    output rwr_cfg_t      cfg,
    output logic          pageReject
);

    rwr_cfg_t cfg_reg;
    rwr_cfg_t cfg_next;
    logic     reject_reg;
    logic     reject_next;
    logic     badLen;
    logic     badBurst;
    logic     badCombo;

    // screen the page; a rejected page changes no setting, it only raises pageReject
    always_comb begin
        badLen   = (pageLen != PAGE_LEN_LONG) && (pageLen != PAGE_LEN_SHORT);
        badBurst = (pageBurst != 8'h00) && (pageBurst != BURST_DEFAULT);
        badCombo = pageFlags[FLAG_DTE_POS] && !pageFlags[FLAG_EER_POS]
                   && !pageFlags[FLAG_PER_POS];
        cfg_next    = cfg_reg;
        reject_next = 1'b0;
        if (pageWrite) begin
            reject_next = badLen || badBurst || badCombo;
            if (!(badLen || badBurst || badCombo)) begin
                cfg_next.tfb       = pageFlags[FLAG_TFB_POS];
                cfg_next.early_correction_flag       = pageFlags[FLAG_EER_POS];
                cfg_next.post_recovered_error       = pageFlags[FLAG_PER_POS];
                cfg_next.stop_transfer_on_error       = pageFlags[FLAG_DTE_POS];
                cfg_next.disable_ecc_correction       = pageFlags[FLAG_DCR_POS];
                cfg_next.readRetry = pageReadRetry;
                // the short page stops before byte 8
                if (pageLen == PAGE_LEN_LONG) begin
                    cfg_next.writeRetry = pageWriteRetry;
                end
            end
        end
    end

    // register the page
    always_ff @(posedge clock) begin
        if (rst) begin
            cfg_reg    <= '{RST_TFB, RST_EER, RST_PER, RST_DTE, RST_DCR,
                            RST_READ_RETRY, RST_WRITE_RETRY};
            reject_reg <= 1'b0;
        end else begin
            cfg_reg    <= cfg_next;
            reject_reg <= reject_next;
        end
    end

    assign cfg        = cfg_reg;
    assign pageReject = reject_reg;

    a_short_page_keep: assert property (@(posedge clock) disable iff (rst)
        pageWrite && pageLen == PAGE_LEN_SHORT |=>
        cfg.writeRetry == $past(cfg.writeRetry))
        else $error("short page altered the write retry count");

    a_burst_reject: assert property (@(posedge clock) disable iff (rst)
        pageWrite && pageBurst != 8'h00 && pageBurst != BURST_DEFAULT |=>
        pageReject && cfg == $past(cfg))
        else $error("bad burst length was not refused");

    a_combo_reject: assert property (@(posedge clock) disable iff (rst)
        pageWrite && pageFlags[FLAG_DTE_POS] && !pageFlags[FLAG_EER_POS]
        && !pageFlags[FLAG_PER_POS] |=> pageReject)
        else $error("forbidden flag combination was accepted");

endmodule

// ### hdl/rwr_pkg.sv
// constants and carrier types of the read/write error recovery policy block
package rwr_pkg;

    // page length codes accepted for the recovery page
    localparam logic [7:0] PAGE_LEN_LONG  = 8'h0A;
    localparam logic [7:0] PAGE_LEN_SHORT = 8'h06;

    // bit positions inside the flag byte of the page
    localparam int FLAG_TFB_POS = 5;
    localparam int FLAG_EER_POS = 3;
    localparam int FLAG_PER_POS = 2;
    localparam int FLAG_DTE_POS = 1;
    localparam int FLAG_DCR_POS = 0;

    // values after reset
    localparam logic       RST_TFB         = 1'b1;
    localparam logic       RST_EER         = 1'b1;
    localparam logic       RST_PER         = 1'b0;
    localparam logic       RST_DTE         = 1'b0;
    localparam logic       RST_DCR         = 1'b0;
    localparam logic [7:0] RST_READ_RETRY  = 8'h10;
    localparam logic [7:0] RST_WRITE_RETRY = 8'h10;

    // fixed correctable burst length, in bits
    localparam logic [7:0] BURST_DEFAULT = 8'h0B;

    // retries done before the programmed ones
    localparam logic [8:0] INTERNAL_RETRIES = 9'h002;

    // positions in the retry table; the table wraps back to the re-seek
    localparam logic [4:0] POS_RESEEK = 5'h03;
    localparam logic [4:0] POS_LAST   = 5'h14;

    // sense keys of the status
    localparam logic [3:0] SENSE_NONE      = 4'h0;
    localparam logic [3:0] SENSE_RECOVERED = 4'h1;
    localparam logic [3:0] SENSE_MEDIUM    = 4'h3;

    typedef enum logic [1:0] {
        ACT_READ,
        ACT_RESEEK,
        ACT_SLICE,
        ACT_OFFSET
    } rwr_action_t;

    typedef struct packed {
        logic       tfb;
        logic       early_correction_flag;
        logic       post_recovered_error;
        logic       stop_transfer_on_error;
        logic       disable_ecc_correction;
        logic [7:0] readRetry;
        logic [7:0] writeRetry;
    } rwr_cfg_t;

    typedef struct packed {
        logic        isWrite;
        logic        isId;
        logic        correctable;
        logic [31:0] addr;
    } rwr_err_t;

    typedef struct packed {
        logic [8:0]        attempt;
        rwr_action_t       action;
        logic signed [2:0] amount;
    } rwr_step_t;

    typedef struct packed {
        logic        check;
        logic [3:0]  senseKey;
        logic [31:0] addr;
    } rwr_status_t;

endpackage

// ### hdl/rwr_recovery.sv
// error recovery policy engine of the drive controller
`timescale 1ns/1ns
module rwr_recovery
    import rwr_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       pageWrite,
    input  wire logic [7:0] pageLen,
    input  wire logic [7:0] pageFlags,
    input  wire logic [7:0] pageReadRetry,
    input  wire logic [7:0] pageBurst,
    input  wire logic [7:0] pageWriteRetry,
    input  wire logic       errStart,
    input  rwr_err_t        errInfo,
    input  wire logic       attemptDone,
    input  wire logic       attemptOk,
    input  wire logic       attemptCorrectable,
    input  wire logic       cmdEnd,
    output rwr_cfg_t        cfg,
    output logic            pageReject,
    output logic            busy,
    output logic            attemptReq,
    output rwr_step_t       step,
    output logic            eccApply,
    output logic            recovered,
    output logic            abortCmd,
    output logic            sendBlock,
    output logic            terminateCmd,
    output logic            statusValid,
    output rwr_status_t     status
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ISSUE,
        ST_WAIT,
        ST_ECC
    } rwr_state_t;

    rwr_state_t  state_reg;
    rwr_state_t  state_next;
    rwr_err_t    err_reg;
    rwr_err_t    err_next;
    logic [8:0]  attempt_reg;
    logic [8:0]  attempt_next;
    logic [8:0]  limit_reg;
    logic [8:0]  limit_next;
    logic [4:0]  pos_reg;
    logic [4:0]  pos_next;
    logic        sawCorr_reg;
    logic        sawCorr_next;
    logic        stepLoad;
    logic        finishOk;
    logic        finishFail;
    logic        corrUsable;
    logic        startUsable;

    logic        busy_reg;
    logic        busy_next;
    logic        attemptReq_reg;
    logic        attemptReq_next;
    logic        eccApply_reg;
    logic        eccApply_next;
    logic        recovered_reg;
    logic        recovered_next;
    logic        abort_reg;
    logic        abort_next;
    logic        sendBlock_reg;
    logic        sendBlock_next;
    logic        terminate_reg;
    logic        terminate_next;
    logic        statusValid_reg;
    logic        statusValid_next;
    rwr_status_t status_reg;
    rwr_status_t status_next;
    logic        pend_reg;
    logic        pend_next;
    logic [31:0] pendAddr_reg;
    logic [31:0] pendAddr_next;

    rwr_page_regs u_page (
        .clock          (clock),
        .rst            (rst),
        .pageWrite      (pageWrite),
        .pageLen        (pageLen),
        .pageFlags      (pageFlags),
        .pageReadRetry  (pageReadRetry),
        .pageBurst      (pageBurst),
        .pageWriteRetry (pageWriteRetry),
        .cfg            (cfg),
        .pageReject     (pageReject)
    );

    rwr_retry_step u_step (
        .clock   (clock),
        .rst     (rst),
        .load    (stepLoad),
        .attempt (attempt_next),
        .pos     (pos_next),
        .step    (step)
    );

    // ECC may only touch data fields of reads, never ID fields or writes
    always_comb begin
        corrUsable  = !err_reg.isWrite && !err_reg.isId && !cfg.disable_ecc_correction;
        startUsable = !errInfo.isWrite && !errInfo.isId && !cfg.disable_ecc_correction
                      && errInfo.correctable;
    end

    // recovery sequencer: one attempt at a time, the read channel answers
    always_comb begin
        state_next   = state_reg;
        err_next     = err_reg;
        attempt_next = attempt_reg;
        limit_next   = limit_reg;
        pos_next     = pos_reg;
        sawCorr_next = sawCorr_reg;
        stepLoad     = 1'b0;
        finishOk     = 1'b0;
        finishFail   = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (errStart) begin
                    err_next     = errInfo;
                    attempt_next = 9'h000;
                    pos_next     = 5'h00;
                    sawCorr_next = startUsable;
                    // programmed count plus the two internal retries
                    limit_next = INTERNAL_RETRIES + {1'b0, errInfo.isWrite ?
                        cfg.writeRetry : cfg.readRetry};
                    if (startUsable && cfg.early_correction_flag) begin
                        state_next = ST_ECC;
                    end else begin
                        state_next = ST_ISSUE;
                    end
                end
            end
            ST_ISSUE: begin
                attempt_next = attempt_reg + 9'h001;
                // table wraps from its last entry back to the re-seek
                pos_next = (pos_reg == POS_LAST) ? POS_RESEEK
                                                 : pos_reg + 5'h01;
                stepLoad   = 1'b1;
                state_next = ST_WAIT;
            end
            ST_WAIT: begin
                if (attemptDone) begin
                    if (attemptOk) begin
                        finishOk   = 1'b1;
                        state_next = ST_IDLE;
                    end else if (attemptCorrectable && corrUsable && cfg.early_correction_flag)
                    begin
                        state_next = ST_ECC;
                    end else begin
                        sawCorr_next = sawCorr_reg
                                       || (attemptCorrectable && corrUsable);
                        if (attempt_reg >= limit_reg) begin
                            // retries spent: correct late or give up
                            if (sawCorr_next) begin
                                state_next = ST_ECC;
                            end else begin
                                finishFail = 1'b1;
                                state_next = ST_IDLE;
                            end
                        end else begin
                            state_next = ST_ISSUE;
                        end
                    end
                end
            end
            ST_ECC: begin
                finishOk   = 1'b1;
                state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // outcome and status; with PER set and DTE clear, a recovered error is held until command end
    always_comb begin
        busy_next        = (state_next != ST_IDLE);
        attemptReq_next  = stepLoad;
        eccApply_next    = (state_reg == ST_ECC) && !cfg.disable_ecc_correction;
        recovered_next   = finishOk;
        abort_next       = finishFail;
        sendBlock_next   = finishFail && cfg.tfb;
        terminate_next   = finishOk && cfg.stop_transfer_on_error;
        statusValid_next = 1'b0;
        status_next      = status_reg;
        pend_next        = pend_reg;
        pendAddr_next    = pendAddr_reg;
        if (finishFail) begin
            statusValid_next = 1'b1;
            status_next      = '{1'b1, SENSE_MEDIUM, err_reg.addr};
            pend_next        = 1'b0;
        end else if (finishOk && cfg.stop_transfer_on_error) begin
            statusValid_next = 1'b1;
            status_next      = '{cfg.post_recovered_error, cfg.post_recovered_error ? SENSE_RECOVERED
                                 : SENSE_NONE, err_reg.addr};
            pend_next        = 1'b0;
        end else if (finishOk && cfg.post_recovered_error) begin
            // only the last recovered error is kept
            pend_next     = 1'b1;
            pendAddr_next = err_reg.addr;
        end else if (cmdEnd && state_reg == ST_IDLE && !errStart) begin
            statusValid_next = 1'b1;
            status_next      = '{pend_reg, pend_reg ? SENSE_RECOVERED
                                 : SENSE_NONE, pendAddr_reg};
            pend_next        = 1'b0;
        end
    end

    // register sequencer and outputs
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg       <= ST_IDLE;
            err_reg         <= '0;
            attempt_reg     <= 9'h000;
            limit_reg       <= 9'h000;
            pos_reg         <= 5'h00;
            sawCorr_reg     <= 1'b0;
            busy_reg        <= 1'b0;
            attemptReq_reg  <= 1'b0;
            eccApply_reg    <= 1'b0;
            recovered_reg   <= 1'b0;
            abort_reg       <= 1'b0;
            sendBlock_reg   <= 1'b0;
            terminate_reg   <= 1'b0;
            statusValid_reg <= 1'b0;
            status_reg      <= '0;
            pend_reg        <= 1'b0;
            pendAddr_reg    <= 32'h0000_0000;
        end else begin
            state_reg       <= state_next;
            err_reg         <= err_next;
            attempt_reg     <= attempt_next;
            limit_reg       <= limit_next;
            pos_reg         <= pos_next;
            sawCorr_reg     <= sawCorr_next;
            busy_reg        <= busy_next;
            attemptReq_reg  <= attemptReq_next;
            eccApply_reg    <= eccApply_next;
            recovered_reg   <= recovered_next;
            abort_reg       <= abort_next;
            sendBlock_reg   <= sendBlock_next;
            terminate_reg   <= terminate_next;
            statusValid_reg <= statusValid_next;
            status_reg      <= status_next;
            pend_reg        <= pend_next;
            pendAddr_reg    <= pendAddr_next;
        end
    end

    assign busy         = busy_reg;
    assign attemptReq   = attemptReq_reg;
    assign eccApply     = eccApply_reg;
    assign recovered    = recovered_reg;
    assign abortCmd     = abort_reg;
    assign sendBlock    = sendBlock_reg;
    assign terminateCmd = terminate_reg;
    assign statusValid  = statusValid_reg;
    assign status       = status_reg;

    // early correction: error taken, ECC state, then the pulse
    sequence s_early_start;
        state_reg == ST_IDLE && errStart && startUsable && cfg.early_correction_flag;
    endsequence

    sequence s_ecc_out;
        ##1 eccApply && recovered && !attemptReq;
    endsequence

    a_early_ecc: assert property (@(posedge clock) disable iff (rst)
        s_early_start |=> s_ecc_out)
        else $error("early correction did not apply ECC at once");

    a_unrec_block: assert property (@(posedge clock) disable iff (rst)
        abortCmd |-> sendBlock == cfg.tfb && statusValid && status.check)
        else $error("failed block handling does not follow the flag");

    a_post_good: assert property (@(posedge clock) disable iff (rst)
        state_reg == ST_IDLE && cmdEnd && !errStart && !pend_reg |=>
        statusValid && !status.check)
        else $error("command end without recovery did not give GOOD");

    a_dte_stop: assert property (@(posedge clock) disable iff (rst)
        recovered |-> terminateCmd == cfg.stop_transfer_on_error)
        else $error("stop on error not applied to a recovered error");

    a_no_ecc_dcr: assert property (@(posedge clock) disable iff (rst)
        eccApply |-> !cfg.disable_ecc_correction)
        else $error("ECC applied while correction is disabled");

    a_retry_limit: assert property (@(posedge clock) disable iff (rst)
        attemptReq |-> step.attempt <= limit_reg
        && limit_reg >= INTERNAL_RETRIES)
        else $error("retry beyond the programmed count plus two");

    a_seq_reseek: assert property (@(posedge clock) disable iff (rst)
        attemptReq && (step.attempt == 9'd3 || step.attempt == 9'd21) |->
        step.action == ACT_RESEEK)
        else $error("attempt 3 or 21 is not a re-seek");

    a_seq_offset: assert property (@(posedge clock) disable iff (rst)
        attemptReq && step.attempt == 9'd20 |->
        step.action == ACT_OFFSET && step.amount == -3'sd3)
        else $error("attempt 20 is not offset minus three");

    a_post_report: assert property (@(posedge clock) disable iff (rst)
        state_reg == ST_IDLE && cmdEnd && !errStart && pend_reg |=>
        statusValid && status.senseKey == SENSE_RECOVERED
        && status.addr == $past(pendAddr_reg))
        else $error("recovered error not posted at command end");

endmodule

// ### hdl/rwr_retry_step.sv
// decoder of one retry attempt into its read channel action
`timescale 1ns/1ns
module rwr_retry_step
    import rwr_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       load,
    input  wire logic [8:0] attempt,
    input  wire logic [4:0] pos,
    output rwr_step_t       step
);

    rwr_step_t step_reg;
    rwr_step_t step_next;

    // table position to action; from position 5 on, pairs of positions share one setting
    always_comb begin
        step_next = step_reg;
        if (load) begin
            step_next.attempt = attempt;
            step_next.amount  = 3'sd0;
            if (pos == POS_RESEEK) begin
                step_next.action = ACT_RESEEK;
            end else if (pos <= 5'h04) begin
                step_next.action = ACT_READ;
            end else if (pos <= 5'h06) begin
                step_next.action = ACT_SLICE;
                step_next.amount = -3'sd1;
            end else if (pos <= 5'h08) begin
                step_next.action = ACT_SLICE;
                step_next.amount = 3'sd1;
            end else begin
                // offsets +1,-1,+2,-2,+3,-3 over positions 9 to 20
                step_next.action = ACT_OFFSET;
                case (pos)
                    5'h09, 5'h0A: step_next.amount = 3'sd1;
                    5'h0B, 5'h0C: step_next.amount = -3'sd1;
                    5'h0D, 5'h0E: step_next.amount = 3'sd2;
                    5'h0F, 5'h10: step_next.amount = -3'sd2;
                    5'h11, 5'h12: step_next.amount = 3'sd3;
                    default:      step_next.amount = -3'sd3;
                endcase
            end
        end
    end

    // hold the step until the next attempt
    always_ff @(posedge clock) begin
        if (rst) begin
            step_reg <= '{9'h000, ACT_READ, 3'sd0};
        end else begin
            step_reg <= step_next;
        end
    end

    assign step = step_reg;

endmodule
